// ===== common/ebc_pkg.sv
// shared constants and types for the byte store access controller
`default_nettype none
package ebc_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam int unsigned  BUS_AW      = 10;          // axi byte address
  localparam logic [7:0]   IDX_CTL     = 8'h1f;       // store_control
  localparam logic [7:0]   IDX_DATA    = 8'h20;       // store_data_byte
  localparam logic [7:0]   IDX_ADDR_LO = 8'h21;       // store_address_low
  localparam logic [7:0]   IDX_ADDR_HI = 8'h22;       // store_address_high
  localparam logic [1:0]   RESP_OKAY   = 2'b00;
  localparam logic [1:0]   RESP_SLVERR = 2'b10;

  // ****************************************************************
  // store geometry and reset values
  // ****************************************************************
  localparam int unsigned  STORE_AW    = 9;           // 512 byte store
  localparam int unsigned  STORE_DEPTH = 512;
  localparam logic [7:0]   ERASED_BYTE = 8'hff;       // erased cell level
  localparam logic [7:0]   DATA_RST    = 8'h00;
  localparam logic [8:0]   ADDR_RST    = 9'h000;

  // ****************************************************************
  // timing constants
  // ****************************************************************
  localparam int unsigned  READ_STALL  = 4;           // cpu cycles
  localparam int unsigned  PGM_STALL   = 2;           // cpu cycles
  localparam int unsigned  MPE_WINDOW  = 4;           // cpu cycles
  localparam int unsigned  OSC_KHZ     = 8000;        // calibrated osc
  localparam int unsigned  ATOMIC_US   = 3400;        // erase plus write
  localparam int unsigned  SPLIT_US    = 1800;        // erase or write
  localparam int unsigned  ATOMIC_TICKS = ATOMIC_US * OSC_KHZ / 1000;
  localparam int unsigned  SPLIT_TICKS  = SPLIT_US * OSC_KHZ / 1000;
  localparam int unsigned  TICK_W      = 16;          // holds 27200
  localparam int unsigned  STALL_W     = 3;

  // ****************************************************************
  // modes, states and field layouts
  // ****************************************************************
  typedef enum logic [1:0] {
    EBC_PM_ATOMIC = 2'b00,
    EBC_PM_ERASE  = 2'b01,
    EBC_PM_WRITE  = 2'b10,
    EBC_PM_RSVD   = 2'b11
  } ebc_mode_t;

  typedef enum logic {
    EBC_IDLE,
    EBC_BUSY
  } ebc_state_t;

  // store_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] rsvd;
    ebc_mode_t  program_mode_field;
    logic       ready_interrupt_enable;
    logic       master_program_enable;
    logic       program_strobe;
    logic       read_strobe;
  } ebc_ctl_t;

  // one programming job, frozen at launch
  typedef struct packed {
    ebc_mode_t           mode;
    logic [STORE_AW-1:0] addr;
    logic [7:0]          data;
  } ebc_op_t;

endpackage : ebc_pkg
`default_nettype wire

// ===== rtl/ebc_top.sv
// byte store access controller with axi4-lite register slave
//
// What this block does
// - store is separate byte-wide address space
// - address, data, control registers bus mapped
// - read strobe stalls processor four cycles
// - programming launch stalls processor two cycles
// - mode 00 strobe in window: erase+write
// - program strobe reads set until done
// - no other operation while programming busy
// - mode 01 strobe erases byte only
// - mode 10 strobe writes without erasing
// - hardware times programming, reports completion
// - duration counted on calibrated oscillator
// - system reset never aborts running programming
// - master enable self-clears after four cycles
// - mode writes ignored while busy; reset 00
// - ready interrupt level when enabled, idle
// - read immediate; reads, address blocked busy
`timescale 1ns/10ps
`default_nettype none
module ebc_top #(
  parameter int unsigned ATOMIC_TICKS_P = ebc_pkg::ATOMIC_TICKS,
  parameter int unsigned SPLIT_TICKS_P  = ebc_pkg::SPLIT_TICKS
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      por_n_in,
  input  wire logic                      osc_clk_in,
  input  wire logic                      global_ie_in,
  input  wire logic [ebc_pkg::BUS_AW-1:0] s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  output logic [1:0]                     s_axi_bresp_out,
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  input  wire logic [ebc_pkg::BUS_AW-1:0] s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  output logic [31:0]                    s_axi_rdata_out,
  output logic [1:0]                     s_axi_rresp_out,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  output logic                           cpu_stall_out,
  output logic                           irq_out
);
  import ebc_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // word index of a byte address; low two bits ignored
  function automatic logic [7:0] word_idx(input logic [BUS_AW-1:0] a);
    word_idx = a[BUS_AW-1:2];
  endfunction : word_idx

  // true for the four store registers
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == IDX_CTL) || (idx == IDX_DATA) ||
                (idx == IDX_ADDR_LO) || (idx == IDX_ADDR_HI);
  endfunction : is_mapped

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]          mem [STORE_DEPTH];     // the byte store itself
  logic                osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic                rst_s1_reg, rst_s2_reg; // sampled system reset
  logic                osc_tick;              // one oscillator period
  ebc_state_t          state_reg, state_next;
  logic [TICK_W-1:0]   tick_cnt_reg, tick_cnt_next;
  ebc_op_t             op_reg, op_next;       // job being programmed
  ebc_mode_t           mode_reg, mode_next;
  logic                mem_we;
  logic [7:0]          mem_wdata;
  logic                busy;
  // bus side state
  logic                aw_have_reg, aw_have_next;
  logic [BUS_AW-1:0]   awaddr_reg, awaddr_next;
  logic                w_have_reg, w_have_next;
  logic [31:0]         wdata_reg, wdata_next;
  logic                wlane_reg, wlane_next;  // byte lane 0 strobe
  logic                bvalid_reg, bvalid_next;
  logic [1:0]          bresp_reg, bresp_next;
  logic                rvalid_reg, rvalid_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic [1:0]          rresp_reg, rresp_next;
  logic [STALL_W-1:0]  stall_cnt_reg, stall_cnt_next;
  logic [STALL_W-1:0]  mpe_cnt_reg, mpe_cnt_next;
  logic                rie_reg, rie_next;
  logic [STORE_AW-1:0] addr_reg, addr_next;
  logic [7:0]          data_reg, data_next;
  logic                irq_reg, irq_next;
  // decode of the write being performed
  logic                wr_fire, ar_fire;
  logic [7:0]          wr_idx;
  ebc_ctl_t            wr_ctl;
  logic                ctl_wr, pgm_try, rd_try;
  logic                pgm_launch, rd_launch;
  logic                mpe;
  logic [7:0]          mem_rd_byte;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  // oscillator and system reset arrive asynchronously
  always_ff @(posedge mclk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_clk_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      rst_s1_reg <= rst_n_in;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign osc_tick = osc_s2_reg & ~osc_s3_reg;

  // ****************************************************************
  // command decode
  // ****************************************************************
  assign busy        = (state_reg == EBC_BUSY);
  assign mpe         = (mpe_cnt_reg != '0);
  assign mem_rd_byte = mem[addr_reg];
  assign wr_fire     = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_idx      = word_idx(awaddr_reg);
  assign wr_ctl      = ebc_ctl_t'(wdata_reg[7:0]);
  assign ctl_wr      = wr_fire & wlane_reg & (wr_idx == IDX_CTL);
  assign pgm_try     = ctl_wr & wr_ctl.program_strobe;
  assign rd_try      = ctl_wr & wr_ctl.read_strobe;
  assign pgm_launch  = pgm_try & mpe & ~busy & (mode_reg != EBC_PM_RSVD);
  assign rd_launch   = rd_try & ~busy & ~pgm_launch;

  // ****************************************************************
  // programming engine, kept alive across system reset
  // ****************************************************************
  // next state of the engine; only power-on reset clears state, count and job
  always_comb begin
    state_next    = state_reg;
    tick_cnt_next = tick_cnt_reg;
    op_next       = op_reg;
    mode_next     = mode_reg;
    mem_we        = 1'b0;
    mem_wdata     = mem[op_reg.addr];
    if (ctl_wr && !busy) begin
      mode_next = wr_ctl.program_mode_field;
    end
    // system reset clears mode when idle
    if (!rst_s2_reg && !busy) begin
      mode_next = EBC_PM_ATOMIC;
    end
    case (state_reg)
      EBC_IDLE: begin
        if (pgm_launch) begin
          op_next.mode  = mode_reg;
          op_next.addr  = addr_reg;
          op_next.data  = data_reg;
          tick_cnt_next = (mode_reg == EBC_PM_ATOMIC)
                        ? TICK_W'(ATOMIC_TICKS_P - 1)
                        : TICK_W'(SPLIT_TICKS_P - 1);
          state_next    = EBC_BUSY;
        end
      end
      EBC_BUSY: begin
        if (osc_tick) begin
          if (tick_cnt_reg == '0) begin
            mem_we     = 1'b1;
            state_next = EBC_IDLE;
          end else begin
            tick_cnt_next = tick_cnt_reg - 1'b1;
          end
        end
        case (op_reg.mode)
          EBC_PM_ERASE: mem_wdata = ERASED_BYTE;
          EBC_PM_WRITE: mem_wdata = mem[op_reg.addr] & op_reg.data;
          default:      mem_wdata = op_reg.data;
        endcase
      end
      default: state_next = EBC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      state_reg    <= EBC_IDLE;
      tick_cnt_reg <= '0;
      op_reg       <= '0;
      mode_reg     <= EBC_PM_ATOMIC;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      op_reg       <= op_next;
      mode_reg     <= mode_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (mem_we) begin
      mem[op_reg.addr] <= mem_wdata;
    end
  end

  // ****************************************************************
  // axi4-lite slave and store registers
  // ****************************************************************
  // new requests wait out a processor stall
  assign s_axi_awready_out = ~aw_have_reg & ~bvalid_reg &
                             (stall_cnt_reg == '0);
  assign s_axi_wready_out  = ~w_have_reg & ~bvalid_reg &
                             (stall_cnt_reg == '0);
  assign s_axi_arready_out = ~rvalid_reg & (stall_cnt_reg == '0);
  assign ar_fire           = s_axi_arvalid_in & s_axi_arready_out;

  // next values of the bus side registers
  always_comb begin
    aw_have_next   = aw_have_reg;
    awaddr_next    = awaddr_reg;
    w_have_next    = w_have_reg;
    wdata_next     = wdata_reg;
    wlane_next     = wlane_reg;
    bvalid_next    = bvalid_reg & ~s_axi_bready_in;
    bresp_next     = bresp_reg;
    rvalid_next    = rvalid_reg & ~s_axi_rready_in;
    rdata_next     = rdata_reg;
    rresp_next     = rresp_reg;
    stall_cnt_next = (stall_cnt_reg != '0) ? stall_cnt_reg - 1'b1
                                           : stall_cnt_reg;
    mpe_cnt_next   = (mpe_cnt_reg != '0) ? mpe_cnt_reg - 1'b1
                                         : mpe_cnt_reg;
    rie_next       = rie_reg;
    addr_next      = addr_reg;
    data_next      = data_reg;
    irq_next       = rie_reg & global_ie_in & ~busy;
    // address and data may come in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata_in;
      wlane_next  = s_axi_wstrb_in[0];
    end
    // perform a write once both halves are held
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      if (wlane_reg) begin
        case (wr_idx)
          IDX_CTL: begin
            rie_next = wr_ctl.ready_interrupt_enable;
            if (wr_ctl.master_program_enable && !mpe) begin
              mpe_cnt_next = STALL_W'(MPE_WINDOW);
            end
          end
          IDX_DATA:    data_next = wdata_reg[7:0];
          IDX_ADDR_LO: if (!busy) addr_next[7:0] = wdata_reg[7:0];
          IDX_ADDR_HI: if (!busy) addr_next[8] = wdata_reg[0];
          default: ;
        endcase
      end
    end
    if (pgm_launch) begin
      stall_cnt_next = STALL_W'(PGM_STALL);
    end
    if (rd_launch) begin
      data_next      = mem_rd_byte;
      stall_cnt_next = STALL_W'(READ_STALL);
    end
    // register read back
    if (ar_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = is_mapped(word_idx(s_axi_araddr_in)) ? RESP_OKAY
                                                         : RESP_SLVERR;
      case (word_idx(s_axi_araddr_in))
        IDX_CTL:     rdata_next = {24'h00_0000, 2'b00, mode_reg, rie_reg,
                                   mpe, busy, 1'b0};
        IDX_DATA:    rdata_next = {24'h00_0000, data_reg};
        IDX_ADDR_LO: rdata_next = {24'h00_0000, addr_reg[7:0]};
        IDX_ADDR_HI: rdata_next = {24'h00_0000, 7'h00, addr_reg[8]};
        default:     rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // bus side registers follow the system reset
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_have_reg   <= 1'b0;
      awaddr_reg    <= '0;
      w_have_reg    <= 1'b0;
      wdata_reg     <= 32'h0000_0000;
      wlane_reg     <= 1'b0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= RESP_OKAY;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      rresp_reg     <= RESP_OKAY;
      stall_cnt_reg <= '0;
      mpe_cnt_reg   <= '0;
      rie_reg       <= 1'b0;
      addr_reg      <= ADDR_RST;
      data_reg      <= DATA_RST;
      irq_reg       <= 1'b0;
    end else begin
      aw_have_reg   <= aw_have_next;
      awaddr_reg    <= awaddr_next;
      w_have_reg    <= w_have_next;
      wdata_reg     <= wdata_next;
      wlane_reg     <= wlane_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
      rresp_reg     <= rresp_next;
      stall_cnt_reg <= stall_cnt_next;
      mpe_cnt_reg   <= mpe_cnt_next;
      rie_reg       <= rie_next;
      addr_reg      <= addr_next;
      data_reg      <= data_next;
      irq_reg       <= irq_next;
    end
  end

  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out  = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out  = rdata_reg;
  assign s_axi_rresp_out  = rresp_reg;
  assign cpu_stall_out    = (stall_cnt_reg != '0);
  assign irq_out          = irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_read_stall;
    @(posedge mclk_in) disable iff (!rst_n_in)
    rd_launch |=> cpu_stall_out [*4] ##1 !cpu_stall_out;
  endproperty
  a_read_stall: assert property (p_read_stall)
    else $error("read stall not four cycles");

  property p_pgm_stall;
    @(posedge mclk_in) disable iff (!rst_n_in)
    pgm_launch |=> cpu_stall_out [*2] ##1 !cpu_stall_out;
  endproperty
  a_pgm_stall: assert property (p_pgm_stall)
    else $error("program stall not two cycles");

  property p_mpe_window;
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(mpe) |-> mpe [*4] ##1 !mpe;
  endproperty
  a_mpe_window: assert property (p_mpe_window)
    else $error("master enable window not four cycles");

  property p_no_mpe_no_pgm;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (pgm_try && !mpe) |-> ##1 !busy || $past(busy);
  endproperty
  a_no_mpe_no_pgm: assert property (p_no_mpe_no_pgm)
    else $error("strobe without master enable started work");

  property p_busy_holds;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (busy && tick_cnt_reg != '0) |=> busy;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("program strobe cleared early");

  property p_busy_refuse;
    @(posedge mclk_in) disable iff (!rst_n_in)
    busy |-> !pgm_launch && !rd_launch;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("operation started while busy");

  property p_mode_frozen;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (busy && ctl_wr) |=> $stable(mode_reg);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("mode changed while busy");

  property p_rsvd_mode;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (pgm_try && mode_reg == EBC_PM_RSVD && !busy) |=> !busy;
  endproperty
  a_rsvd_mode: assert property (p_rsvd_mode)
    else $error("reserved mode started programming");

  property p_irq_level;
    @(posedge mclk_in) disable iff (!rst_n_in)
    ##1 irq_out == $past(rie_reg & global_ie_in & ~busy);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("ready interrupt level wrong");

  property p_read_data;
    @(posedge mclk_in) disable iff (!rst_n_in)
    rd_launch |=> data_reg == $past(mem_rd_byte);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read strobe did not load data byte");

endmodule : ebc_top
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the byte store access controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ebc_pkg::*;
  // ****************************************************************
  // stimulus, observation and bookkeeping
  // ****************************************************************
  localparam logic [9:0] A_CTL = {IDX_CTL, 2'b00};
  localparam logic [9:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [9:0] A_LO  = {IDX_ADDR_LO, 2'b00};
  localparam logic [9:0] A_HI  = {IDX_ADDR_HI, 2'b00};
  logic        mclk, osc, rst_n, por_n, gie, awv, wv, arv;
  logic        awr, wrdy, arr, bv, rv, stall, irq;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0]  bresp, rresp, rd_r, wr_r, m;
  logic [3:0]  ws;                     // write byte lane strobes
  logic [7:0]  model [STORE_DEPTH];   // expected store contents
  logic [8:0]  a, a0, a1;
  logic [7:0]  d;
  logic [1:0]  modes [6] = '{2'b01, 2'b10, 2'b00, 2'b01, 2'b11, 2'b00};
  int          error_cnt, compares, stall_cnt, stall_base, seed;

  // short programming counts keep the run brief
  ebc_top #(.ATOMIC_TICKS_P(20), .SPLIT_TICKS_P(10)) uut (
    .mclk_in(mclk), .rst_n_in(rst_n), .por_n_in(por_n), .osc_clk_in(osc),
    .global_ie_in(gie), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1),
    .cpu_stall_out(stall), .irq_out(irq));

  // oscillator phase unrelated to the system clock
  initial begin mclk = 0; forever #4 mclk = ~mclk; end
  initial begin osc = 0; #3; forever #62.5 osc = ~osc; end
  // stall cycles seen by the processor side
  always @(posedge mclk) if (stall === 1'b1) stall_cnt <= stall_cnt + 1;

  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // handshakes sampled at negedge, so the next rising edge acts on them
  task automatic wr(input logic [9:0] ad, input logic [7:0] dd);
    logic ta, tw, b;
    awaddr <= ad;
    wdata <= {24'h00_0000, dd};
    awv <= 1'b1;
    wv <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge mclk);
      ta = awv & awr;
      tw = wv & wrdy;
      b = bv;
      wr_r = bresp;
      @(posedge mclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (b) return;
    end
    error_cnt++;
    print_verdict();
  endtask : wr

  task automatic rd(input logic [9:0] ad);
    logic t, b;
    araddr <= ad;
    arv <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge mclk);
      t = arv & arr;
      b = rv;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge mclk);
      if (t) arv <= 1'b0;
      if (b) return;
    end
    error_cnt++;
    print_verdict();
  endtask : rd

  function automatic logic [7:0] exp_byte(input logic [1:0] md,
                                          input logic [7:0] old, dd);
    case (md)
      2'b00: return dd;
      2'b01: return ERASED_BYTE;
      2'b10: return old & dd;   // unerased cell only loses bits
      default: return old;
    endcase
  endfunction : exp_byte

  // ****************************************************************
  // programming launch and read-back
  // ****************************************************************
  task automatic launch(input logic [1:0] md, input logic [8:0] ad,
                        input logic [7:0] dd);
    wr(A_CTL, {2'b00, md, 4'b1000});
    wr(A_LO, ad[7:0]);
    wr(A_HI, {7'h00, ad[8]});
    wr(A_DAT, dd);
    stall_base = stall_cnt;
    wr(A_CTL, {2'b00, md, 4'b1100});
    wr(A_CTL, {2'b00, md, 4'b1110});
    model[ad] = exp_byte(md, model[ad], dd);
  endtask : launch

  task automatic settle(input logic [8:0] ad);
    rd(A_CTL);
    for (int n = 0; n < 300 && rd_d[1] !== 1'b0; n++) rd(A_CTL);
    chk(32'(rd_d[1]), 32'h0);
    wr(A_LO, ad[7:0]);
    wr(A_HI, {7'h00, ad[8]});
    stall_base = stall_cnt;
    wr(A_CTL, 8'h09);
    repeat (6) @(posedge mclk);
    chk(stall_cnt - stall_base, READ_STALL);
    rd(A_DAT);
    chk(rd_d, {24'h00_0000, model[ad]});
    chk(32'(irq), 32'h1);
  endtask : settle

  initial begin
    seed = 32'h072b_25cf;
    {rst_n, por_n, awv, wv, arv, awaddr, araddr, wdata} = '0;
    gie = 1'b1;
    ws = 4'h1;
    repeat (2) @(posedge mclk);
    por_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // unmapped place answers an error with zero data
    rd(10'h000);
    chk(32'(rd_r), 32'(RESP_SLVERR));
    chk(rd_d, 32'h0);
    rd(A_CTL);
    chk(rd_d, 32'h0);
    // byte lane 0 off: answered, nothing lands
    ws <= 4'h0;
    wr(A_DAT, 8'h5a);
    ws <= 4'h1;
    chk(32'(wr_r), 32'(RESP_OKAY));
    rd(A_DAT);
    chk(rd_d, {24'h00_0000, DATA_RST});
    // unmapped place refuses the write
    wr(10'h000, 8'h00);
    chk(32'(wr_r), 32'(RESP_SLVERR));
    // enable visible, then gone; late strobe does nothing
    wr(A_CTL, 8'h04);
    rd(A_CTL);
    chk(rd_d, 32'h4);
    repeat (4) @(posedge mclk);
    wr(A_CTL, 8'h02);
    rd(A_CTL);
    chk(rd_d, 32'h0);
    // ready interrupt follows both enables
    wr(A_CTL, 8'h08);
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h1);
    gie <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0);
    gie <= 1'b1;
    a0 = 9'($random(seed));
    a1 = a0 ^ 9'h155;
    for (int i = 0; i < 6; i++) begin
      m = modes[i];
      a = (i inside {2, 3, 4}) ? a1 : a0;
      d = 8'($random(seed));
      launch(m, a, d);
      repeat (6) @(posedge mclk);
      chk(stall_cnt - stall_base, (m == 2'b11) ? 0 : PGM_STALL);
      rd(A_CTL);
      chk(rd_d, {26'h0, m, 2'b10, m != 2'b11, 1'b0});
      chk(32'(irq), 32'(m == 2'b11));
      if (m != 2'b11) begin
        // address, mode and read refused while busy
        wr(A_LO, ~a[7:0]);
        wr(A_CTL, 8'h39);
        rd(A_CTL);
        chk(32'(rd_d[5:4]), 32'(m));
        rd(A_DAT);
        chk(rd_d, {24'h00_0000, d});
        rd(A_LO);
        chk(rd_d, {24'h00_0000, a[7:0]});
      end
      if (i == 5) begin
        // bus reset mid-programming must not abort it
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(A_CTL);
        chk(32'(rd_d[1]), 32'h1);
      end
      settle(a);
    end
    // idle bus reset returns the mode field to zero
    wr(A_CTL, 8'h30);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(A_CTL);
    chk(rd_d, 32'h0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
